// file: core/readout_pkg.sv
package readout_pkg;

  // Register port
  localparam int REG_AW = 8;
  localparam int REG_DW = 16;
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] ERR_ADDR = 8'h04;
  localparam logic [7:0] BLACK_ADDR = 8'h08;
  localparam logic [7:0] STAT_ADDR = 8'h0c;

  // Control register fields
  localparam int CTRL_MASTER_BIT = 0;
  localparam int CTRL_RAW_BIT = 1;
  localparam int CTRL_COLOUR_BIT = 2;
  localparam int CTRL_INTERLACE_BIT = 3;
  localparam int CTRL_PCLK_INV_BIT = 4;
  localparam int CTRL_BIN_LSB = 5;
  localparam int CTRL_MIRROR_COL_BIT = 7;
  localparam int CTRL_MIRROR_ROW_BIT = 8;
  localparam logic [15:0] CTRL_RESET = 16'h0001;
  localparam logic [1:0] BIN_TWO = 2'h1;
  localparam int ERR_CLEAR_BIT = 0;

  // Array geometry
  localparam int COL_W = 10;
  localparam int ROW_W = 10;
  localparam logic [9:0] ARRAY_COLS = 10'h30e;
  localparam logic [9:0] ARRAY_ROWS = 10'h1ec;
  localparam logic [9:0] BLACK_COLS = 10'h01a;
  localparam logic [9:0] BLACK_ROWS = 10'h008;
  localparam logic [9:0] RAW_ROW_FIRST = 10'h002;
  localparam logic [9:0] RAW_ROWS = 10'h004;
  localparam logic [9:0] ACT_COLS = 10'h2f1;
  localparam logic [9:0] ACT_ROWS = 10'h1e1;
  localparam logic [9:0] ACT_COL0 = 10'h01c;
  localparam logic [9:0] ACT_ROW0 = 10'h009;
  localparam logic [9:0] OUT_COLS = 10'h2f0;
  localparam logic [9:0] OUT_ROWS = 10'h1e0;

  // Timing counts in master clock cycles and rows
  localparam logic [9:0] HBLANK_COLS = 10'h05e;
  localparam logic [9:0] VBLANK_ROWS = 10'h02d;
  localparam logic [9:0] ROW_LEN = ARRAY_COLS + HBLANK_COLS;
  localparam logic [9:0] FRAME_ROWS = ARRAY_ROWS + VBLANK_ROWS;

  // Statistics accumulator
  localparam int SUM_W = 29;
  localparam logic [28:0] SUM_RESET = 29'h0;

  typedef enum logic [2:0] {
    SCAN_IDLE = 3'b001,
    SCAN_ROW = 3'b010,
    SCAN_WAIT = 3'b100
  } scan_state_t;

endpackage

// file: core/dark_average.sv
`timescale 1ns/1ns
`default_nettype none
module dark_average #(
  parameter int W = 10,
  parameter int SHIFT = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic take,
  input wire logic [W-1:0] sample,
  output logic [W-1:0] avg
);
  logic [W+SHIFT-1:0] acc_r;
  logic [W+SHIFT-1:0] acc_nxt;
  logic [W+SHIFT:0] sum;

  if (SHIFT < 1 || SHIFT > 6) begin : bad_shift
    $error("dark_average: SHIFT out of range");
  end

  assign avg = acc_r[W+SHIFT-1:SHIFT];

  // Running average: acc += sample - acc/2^SHIFT
  always_comb begin
    sum = {1'b0, acc_r} + {{(SHIFT+1){1'b0}}, sample} - {{(SHIFT+1){1'b0}}, avg};
    if (load) begin
      acc_nxt = {load_val, {SHIFT{1'b0}}};
    end else if (take) begin
      acc_nxt = sum[W+SHIFT-1:0];
    end else begin
      acc_nxt = acc_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_r <= '0;
    end else if (ce) begin
      acc_r <= acc_nxt;
    end
  end
endmodule // dark_average
`default_nettype wire

// file: core/image_readout.sv
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Master drives line start sync; slave takes it as input.
// - Master drives frame start sync; slave takes it as input.
// - Line qualifier high only while the data bus is valid; frame qualifier high from first to last word of a frame.
// - Output enable low floats only the ten data outputs.
// - Error output is the stereo error flag, ungated.
// - Addressing spans 782 columns by 492 rows.
// - Left 26 columns and top eight rows are optically black.
// - Black row data drives automatic black level adjustment.
// - Raw mode also outputs the middle four black rows.
// - Active region is 753 columns by 481 rows.
// - Extra active column and row keep mirrored readout on same colour.
// - Binning combines adjacent pixels only, no colour skipping.
// - Interlaced fields hold red/green rows or blue/green rows.
// - Colour bit set uses first green black value; clear uses all.
// - Black and row noise correction same for every colour.
// - Exposure and gain statistics use all three colours.
// - One pixel word per pixel clock period while line valid high.
// - Pixel clock is inverted master clock; binning stretches it.
// - Control bit 4 inverts pixel clock polarity.
module image_readout #(
  parameter int PIX_W = 10,
  parameter int AVG_SHIFT = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [readout_pkg::REG_AW-1:0] reg_addr,
  input wire logic [readout_pkg::REG_DW-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [readout_pkg::REG_DW-1:0] reg_rdata,
  output logic [readout_pkg::COL_W-1:0] array_col,
  output logic [readout_pkg::ROW_W-1:0] array_row,
  input wire logic [PIX_W-1:0] array_data,
  input wire logic output_enable,
  output logic [PIX_W-1:0] data_out,
  output logic data_oe,
  output logic line_valid,
  output logic frame_valid,
  output logic pixel_clock_out,
  output logic error_out,
  input wire logic line_start_sync_in,
  output logic line_start_sync_out,
  output logic line_start_sync_oe,
  input wire logic frame_start_sync_in,
  output logic frame_start_sync_out,
  output logic frame_start_sync_oe
);
  import readout_pkg::*;

  if (PIX_W < 8 || PIX_W > 12 || AVG_SHIFT < 1 || AVG_SHIFT > 6) begin : bad_param
    $error("image_readout: parameter out of range");
  end

  // Control fields
  logic [REG_DW-1:0] ctrl_r, ctrl_nxt, rdata_r, rdata_nxt;
  logic master, raw_mode, colour_bit, interlace, pclk_inv, mirror_col, mirror_row;
  logic bin2, bin4;
  logic [1:0] bin_code, bin_mask;
  assign master = ctrl_r[CTRL_MASTER_BIT];
  assign raw_mode = ctrl_r[CTRL_RAW_BIT];
  assign colour_bit = ctrl_r[CTRL_COLOUR_BIT];
  assign interlace = ctrl_r[CTRL_INTERLACE_BIT];
  assign pclk_inv = ctrl_r[CTRL_PCLK_INV_BIT];
  assign mirror_col = ctrl_r[CTRL_MIRROR_COL_BIT];
  assign mirror_row = ctrl_r[CTRL_MIRROR_ROW_BIT];
  assign bin_code = ctrl_r[CTRL_BIN_LSB +: 2];
  assign bin4 = bin_code[1];
  assign bin2 = (bin_code == BIN_TWO);
  assign bin_mask = {bin4, bin2 | bin4};

  // Pin synchronisers
  logic ls_s1, ls_s2, ls_s3, fs_s1, fs_s2, fs_s3, oe_s1, oe_s2;
  logic ls_edge, fs_edge;
  always_ff @(posedge clk) begin
    if (rst) begin
      {ls_s1, ls_s2, ls_s3} <= 3'h0;
      {fs_s1, fs_s2, fs_s3} <= 3'h0;
      {oe_s1, oe_s2} <= 2'h0;
    end else if (ce) begin
      {ls_s1, ls_s2, ls_s3} <= {line_start_sync_in, ls_s1, ls_s2};
      {fs_s1, fs_s2, fs_s3} <= {frame_start_sync_in, fs_s1, fs_s2};
      {oe_s1, oe_s2} <= {output_enable, oe_s1};
    end
  end
  assign ls_edge = ls_s2 & ~ls_s3;
  assign fs_edge = fs_s2 & ~fs_s3;

  // Scan sequencer
  scan_state_t state_r, state_nxt;
  logic [COL_W-1:0] col_r, col_nxt;
  logic [ROW_W-1:0] row_r, row_nxt;
  logic field_r, field_nxt, lsync_r, lsync_nxt, fsync_r, fsync_nxt, err_r, err_nxt;
  logic err_set, err_clr;

  assign err_set = !master && (state_r == SCAN_ROW) && (ls_edge || fs_edge);
  assign err_clr = reg_write && (reg_addr == ERR_ADDR) && reg_wdata[ERR_CLEAR_BIT];

  always_comb begin
    state_nxt = state_r;
    col_nxt = col_r;
    row_nxt = row_r;
    field_nxt = field_r;
    lsync_nxt = 1'b0;
    fsync_nxt = 1'b0;
    err_nxt = err_set | (err_r & ~err_clr);
    case (state_r)
      SCAN_IDLE: begin
        if (master || fs_edge) begin
          state_nxt = SCAN_ROW;
          col_nxt = '0;
          row_nxt = '0;
          lsync_nxt = master;
          fsync_nxt = master;
        end
      end
      SCAN_ROW: begin
        if (col_r == ROW_LEN - 10'h001) begin
          col_nxt = '0;
          if (row_r == FRAME_ROWS - 10'h001) begin
            row_nxt = '0;
            field_nxt = interlace & ~field_r;
            if (!master) begin
              state_nxt = SCAN_IDLE;
            end else begin
              lsync_nxt = 1'b1;
              fsync_nxt = 1'b1;
            end
          end else begin
            row_nxt = row_r + 10'h001;
            if (!master) begin
              state_nxt = SCAN_WAIT;
            end else begin
              lsync_nxt = 1'b1;
            end
          end
        end else begin
          col_nxt = col_r + 10'h001;
        end
      end
      SCAN_WAIT: begin
        if (ls_edge) begin
          state_nxt = SCAN_ROW;
        end
      end
      default: begin
        state_nxt = SCAN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= SCAN_IDLE;
      col_r <= '0;
      row_r <= '0;
      field_r <= 1'b0;
      lsync_r <= 1'b0;
      fsync_r <= 1'b0;
      err_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      col_r <= col_nxt;
      row_r <= row_nxt;
      field_r <= field_nxt;
      lsync_r <= lsync_nxt;
      fsync_r <= fsync_nxt;
      err_r <= err_nxt;
    end
  end

  // Stage 0: window decode and addressing
  logic [COL_W-1:0] ck, pcol, acol_r;
  logic [ROW_W-1:0] rk, prow, arow_r, last_rk;
  logic run, act_row, raw_row, field_ok, win_col, take0, last0;
  assign run = (state_r == SCAN_ROW);
  assign ck = col_r - ACT_COL0;
  assign rk = row_r - ACT_ROW0;
  assign act_row = (row_r >= ACT_ROW0) && (row_r < ACT_ROW0 + OUT_ROWS);
  assign field_ok = !interlace || (rk[0] == field_r);
  assign raw_row = raw_mode && (row_r >= RAW_ROW_FIRST)
                   && (row_r < RAW_ROW_FIRST + RAW_ROWS);
  assign win_col = (col_r >= ACT_COL0) && (col_r < ACT_COL0 + OUT_COLS);
  assign take0 = run && win_col && ((act_row && field_ok) || raw_row);
  assign last_rk = (interlace && !field_r) ? OUT_ROWS - 10'h002 : OUT_ROWS - 10'h001;
  assign last0 = act_row && (rk == last_rk);

  // Mirrored readout starts one column/row further in, on the same colour
  always_comb begin
    if (win_col && mirror_col) begin
      pcol = ACT_COL0 + OUT_COLS - ck;
    end else if (col_r < ARRAY_COLS) begin
      pcol = col_r;
    end else begin
      pcol = '0;
    end
    if (act_row && mirror_row) begin
      prow = ACT_ROW0 + OUT_ROWS - rk;
    end else if (row_r < ARRAY_ROWS) begin
      prow = row_r;
    end else begin
      prow = '0;
    end
  end

  // Stage 1 flags, aligned with array_data
  logic take_s1, drow_s1, dcol_s1, green_s1, gend_s1, rstart_s1, fend_s1, raw_s1, last_s1;
  always_ff @(posedge clk) begin
    if (rst) begin
      acol_r <= '0;
      arow_r <= '0;
      {take_s1, drow_s1, dcol_s1, green_s1, gend_s1} <= 5'h0;
      {rstart_s1, fend_s1, raw_s1, last_s1} <= 4'h0;
    end else if (ce) begin
      acol_r <= pcol;
      arow_r <= prow;
      take_s1 <= take0;
      drow_s1 <= run && (row_r < BLACK_ROWS) && (col_r < ARRAY_COLS);
      dcol_s1 <= run && (row_r < ARRAY_ROWS) && (col_r < BLACK_COLS);
      green_s1 <= !prow[0] && !pcol[0];
      gend_s1 <= ((ck[1:0] & bin_mask) == bin_mask);
      rstart_s1 <= run && (col_r == '0);
      fend_s1 <= run && (col_r == ROW_LEN - 10'h001) && (row_r == FRAME_ROWS - 10'h001);
      raw_s1 <= raw_row;
      last_s1 <= last0;
    end
  end
  assign array_col = acol_r;
  assign array_row = arow_r;

  // Black level from black rows, row noise from black columns
  logic [PIX_W-1:0] black_avg, row_avg;
  dark_average #(.W(PIX_W), .SHIFT(AVG_SHIFT)) u_black (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .load(1'b0),
    .load_val('0),
    .take(drow_s1 && (!colour_bit || green_s1)),
    .sample(array_data),
    .avg(black_avg)
  );
  dark_average #(.W(PIX_W), .SHIFT(AVG_SHIFT)) u_row (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .load(rstart_s1),
    .load_val(black_avg),
    .take(dcol_s1),
    .sample(array_data),
    .avg(row_avg)
  );

  // Stage 2: correction, binning, qualifiers, statistics
  logic [PIX_W+1:0] acc_r, acc_nxt, grp_sum;
  logic [PIX_W:0] diff;
  logic [PIX_W-1:0] corr, word, data_r, data_nxt;
  logic [2:0] hold_r, hold_nxt, bin_len;
  logic fv_r, fv_nxt, lastw_r, lastw_nxt, emit;
  logic [SUM_W-1:0] sum_r, sum_nxt;
  logic [REG_DW-1:0] stat_r, stat_nxt;

  assign bin_len = bin4 ? 3'h4 : (bin2 ? 3'h2 : 3'h1);
  assign emit = take_s1 && gend_s1;

  always_comb begin
    diff = {1'b0, array_data} - {1'b0, row_avg};
    corr = raw_mode ? array_data : (diff[PIX_W] ? '0 : diff[PIX_W-1:0]);
    grp_sum = acc_r + {2'b00, corr};
    if (bin4) begin
      word = grp_sum[PIX_W+1:2];
    end else if (bin2) begin
      word = grp_sum[PIX_W:1];
    end else begin
      word = grp_sum[PIX_W-1:0];
    end
    acc_nxt = (take_s1 && !gend_s1) ? grp_sum : '0;
    hold_nxt = emit ? bin_len : ((hold_r != 3'h0) ? hold_r - 3'h1 : 3'h0);
    data_nxt = emit ? word : ((hold_r <= 3'h1) ? '0 : data_r);
    fv_nxt = fv_r;
    lastw_nxt = lastw_r;
    if (emit) begin
      fv_nxt = 1'b1;
      lastw_nxt = last_s1;
    end else if (hold_r == 3'h1 && lastw_r) begin
      fv_nxt = 1'b0;
      lastw_nxt = 1'b0;
    end
    stat_nxt = stat_r;
    sum_nxt = sum_r;
    if (fend_s1) begin
      stat_nxt = sum_r[SUM_W-1 -: REG_DW];
      sum_nxt = SUM_RESET;
    end else if (emit && !raw_s1) begin
      sum_nxt = sum_r + {{(SUM_W-PIX_W){1'b0}}, word};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_r <= '0;
      data_r <= '0;
      hold_r <= 3'h0;
      fv_r <= 1'b0;
      lastw_r <= 1'b0;
      sum_r <= SUM_RESET;
      stat_r <= '0;
    end else if (ce) begin
      acc_r <= acc_nxt;
      data_r <= data_nxt;
      hold_r <= hold_nxt;
      fv_r <= fv_nxt;
      lastw_r <= lastw_nxt;
      sum_r <= sum_nxt;
      stat_r <= stat_nxt;
    end
  end

  // Pixel clock phase follows the column counter in binned modes
  logic [COL_W-1:0] cm1;
  logic pclk_div;
  assign cm1 = col_r - 10'h001;
  assign pclk_div = bin4 ? cm1[1] : cm1[0];
  assign pixel_clock_out = ((bin2 || bin4) ? pclk_div : ~clk) ^ pclk_inv;

  assign data_out = data_r;
  assign data_oe = oe_s2;
  assign line_valid = (hold_r != 3'h0);
  assign frame_valid = fv_r;
  assign error_out = err_r;
  assign line_start_sync_out = lsync_r;
  assign line_start_sync_oe = master;
  assign frame_start_sync_out = fsync_r;
  assign frame_start_sync_oe = master;

  // Register port
  always_comb begin
    ctrl_nxt = ctrl_r;
    rdata_nxt = '0;
    if (reg_write && reg_addr == CTRL_ADDR) begin
      ctrl_nxt = reg_wdata;
    end
    if (reg_read) begin
      case (reg_addr)
        CTRL_ADDR: rdata_nxt = ctrl_r;
        ERR_ADDR: rdata_nxt = {{(REG_DW-1){1'b0}}, err_r};
        BLACK_ADDR: rdata_nxt = {{(REG_DW-PIX_W){1'b0}}, black_avg};
        STAT_ADDR: rdata_nxt = stat_r;
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= CTRL_RESET;
      rdata_r <= '0;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign reg_rdata = rdata_r;

  // Checks
  sync_dir_a: assert property (@(posedge clk) disable iff (rst)
    line_start_sync_oe == ctrl_r[CTRL_MASTER_BIT] && frame_start_sync_oe == line_start_sync_oe)
    else $error("sync pin direction wrong");
  frame_sync_a: assert property (@(posedge clk) disable iff (rst || !ce)
    frame_start_sync_out |-> line_start_sync_out && col_r == '0 && row_r == '0 && master)
    else $error("frame sync out of place");
  qual_pair_a: assert property (@(posedge clk) disable iff (rst)
    line_valid |-> frame_valid)
    else $error("line valid outside frame");
  oe_path_a: assert property (@(posedge clk) disable iff (rst || !ce)
    $rose(output_enable) ##1 ce ##1 ce |-> data_oe)
    else $error("data enable did not follow pin");
  error_pin_a: assert property (@(posedge clk) disable iff (rst || !ce)
    err_set |=> error_out)
    else $error("error output missed flag");
  addr_span_a: assert property (@(posedge clk) disable iff (rst)
    array_col < ARRAY_COLS && array_row < ARRAY_ROWS)
    else $error("array address out of range");
  mirror_col_a: assert property (@(posedge clk) disable iff (rst || !ce)
    take0 && mirror_col |=> acol_r > ACT_COL0 && acol_r <= ACT_COL0 + OUT_COLS)
    else $error("mirrored column outside window");
  word_rate_a: assert property (@(posedge clk) disable iff (rst || !ce)
    $rose(line_valid) |-> line_valid [*8])
    else $error("line valid broke within a row");
  pclk_bin2_a: assert property (@(posedge clk) disable iff (rst || !ce || state_r != SCAN_ROW)
    bin2 && !pclk_inv && $rose(pixel_clock_out) |=> !pixel_clock_out ##1 pixel_clock_out)
    else $error("pixel clock wrong in bin two");
  black_take_a: assert property (@(posedge clk) disable iff (rst || !ce)
    colour_bit && drow_s1 && !green_s1 |=> $stable(black_avg))
    else $error("black level used non green pixel");
endmodule // image_readout
`default_nettype wire

// file: sim/pixel_capture.sv
`timescale 1ns/1ns
`default_nettype none
module pixel_capture (
  input wire logic pixel_clock_out,
  input wire logic [9:0] data_out,
  input wire logic data_oe,
  input wire logic line_valid,
  input wire logic frame_valid,
  output logic [9:0] words,
  output logic [9:0] first_word,
  output logic [9:0] bad_fv,
  output logic done_tgl
);
  logic [9:0] n = 10'h000;
  logic [9:0] fw = 10'h000;
  logic [9:0] nb = 10'h000;
  logic [9:0] last = 10'h000;
  logic [9:0] seen;

  initial done_tgl = 1'b0;

  // Latch words on the rising pixel clock; a floated bus reads as junk
  always @(posedge pixel_clock_out) begin
    if (line_valid === 1'b1) begin
      seen = (data_oe === 1'b1) ? data_out : ~last;
      if (n == 10'h000) fw = seen;
      if (frame_valid !== 1'b1) nb = nb + 10'h001;
      n = n + 10'h001;
      last = seen;
    end
  end

  // Report a finished line once the last edge has landed; no words means no line
  always @(negedge line_valid) begin
    #1;
    if (n != 10'h000) begin
      words = n;
      first_word = fw;
      bad_fv = nb;
      n = 10'h000;
      nb = 10'h000;
      done_tgl = ~done_tgl;
    end
  end
endmodule // pixel_capture
`default_nettype wire

// file: sim/image_sensor_pixel_readout_tb.sv
`timescale 1ns/1ns
`default_nettype none
module image_sensor_pixel_readout_tb;
  import readout_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [REG_AW-1:0] reg_addr = 8'h00;
  logic [REG_DW-1:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic output_enable = 1'b1;
  logic ls_in = 1'b0;
  logic fs_in = 1'b0;
  logic [REG_DW-1:0] reg_rdata;
  logic [COL_W-1:0] array_col;
  logic [ROW_W-1:0] array_row;
  logic [9:0] array_data, data_out, words, first_word, bad_fv;
  logic data_oe, line_valid, frame_valid, pixel_clock_out, error_out, done_tgl;
  logic ls_out, ls_oe, fs_out, fs_oe, prev, p1;
  logic [9:0] k = 10'h000;
  logic [10:0] e;
  logic [10:0] exp_q[$];
  int errors = 0;
  int comparisons = 0;
  int n;

  always #20 clk = ~clk;
  assign array_data = array_col * 10'h003 + array_row + k;

  image_readout uut (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .array_col(array_col), .array_row(array_row), .array_data(array_data),
    .output_enable(output_enable), .data_out(data_out), .data_oe(data_oe),
    .line_valid(line_valid), .frame_valid(frame_valid), .pixel_clock_out(pixel_clock_out),
    .error_out(error_out), .line_start_sync_in(ls_in), .line_start_sync_out(ls_out),
    .line_start_sync_oe(ls_oe), .frame_start_sync_in(fs_in), .frame_start_sync_out(fs_out),
    .frame_start_sync_oe(fs_oe));

  pixel_capture cap (.pixel_clock_out(pixel_clock_out), .data_out(data_out),
    .data_oe(data_oe), .line_valid(line_valid), .frame_valid(frame_valid), .words(words),
    .first_word(first_word), .bad_fv(bad_fv), .done_tgl(done_tgl));

  function automatic logic [9:0] pix(input int c, input int r);
    return 10'(c * 3 + r) + k;
  endfunction

  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic finish_test;
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [15:0] x, input string msg);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 check(reg_rdata === x, msg);
  endtask

  task automatic pclk_at_high(input logic v, input string msg);
    @(posedge clk);
    #10 check(pixel_clock_out === v, msg);
  endtask

  task automatic wait_pulse(input bit frame, input int lim);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while ((frame ? fs_out : ls_out) !== 1'b1 && n < lim);
  endtask

  task automatic pulse_sync(input bit frame);
    @(posedge clk);
    if (frame) fs_in <= 1'b1;
    else ls_in <= 1'b1;
    repeat (4) @(posedge clk);
    fs_in <= 1'b0;
    ls_in <= 1'b0;
  endtask

  task automatic wait_lines;
    for (n = 0; n < 20000 && exp_q.size() != 0; n++) @(posedge clk);
    check(exp_q.size() == 0, "lines missing");
  endtask

  // Compare each captured line with the oldest note
  initial begin
    #1;
    forever begin
      @(done_tgl);
      if (exp_q.size() == 0) begin
        check(1'b0, "unexpected line");
      end else begin
        e = exp_q.pop_front();
        check(words === OUT_COLS, "words per line");
        check(bad_fv === 10'h000, "frame valid low in line");
        if (e[10]) check(first_word === e[9:0], "first word");
      end
    end
  end

  initial begin
    #(40 * 60000);
    errors++;
    $display("[ERR] %0t timeout", $time);
    finish_test();
  end

  initial begin
    void'($urandom(53));
    k <= 10'($urandom);
    do_reset();
    reg_rd(CTRL_ADDR, CTRL_RESET, "ctrl reset");
    check(ls_oe === 1'b1 && fs_oe === 1'b1, "master sync drive");
    check(data_oe === 1'b1, "data enable");
    reg_rd(ERR_ADDR, 16'h0000, "err reset");
    reg_wr(8'h10, 16'hffff);
    reg_rd(8'h10, 16'h0000, "unmapped read");
    reg_rd(CTRL_ADDR, CTRL_RESET, "unmapped write");
    // Master sync pulses
    do_reset();
    wait_pulse(1'b1, 4);
    check(fs_out === 1'b1, "frame sync pulse");
    wait_pulse(1'b0, 2000);
    wait_pulse(1'b0, 2000);
    check(n == int'(ROW_LEN), "line sync period");
    // Raw rows, mirrored rows, one interlaced field, colour black level, linear only
    do_reset();
    reg_wr(CTRL_ADDR, 16'h010f);
    for (int r = 2; r < 6; r++) exp_q.push_back({1'b1, pix(28, r)});
    exp_q.push_back({1'b1, pix(28, 489)});
    exp_q.push_back({1'b1, pix(28, 487)});
    pclk_at_high(1'b0, "pixel clock inverted master");
    wait_lines();
    // Mirrored columns with inverted pixel clock
    do_reset();
    reg_wr(CTRL_ADDR, 16'h0093);
    exp_q.push_back({1'b1, pix(780, 2)});
    pclk_at_high(1'b1, "pixel clock polarity");
    wait_lines();
    // Output enable low floats data only
    do_reset();
    output_enable <= 1'b0;
    exp_q.push_back({1'b0, 10'h000});
    wait_lines();
    check(data_oe === 1'b0, "data float");
    output_enable <= 1'b1;
    // Column bin two and four stretch the pixel clock; clock enable freezes it
    do_reset();
    reg_wr(CTRL_ADDR, 16'h0021);
    repeat (4) @(posedge clk);
    #10 prev = pixel_clock_out;
    for (int i = 0; i < 8; i++) begin
      pclk_at_high(~prev, "bin two pixel clock");
      prev = pixel_clock_out;
    end
    do_reset();
    reg_wr(CTRL_ADDR, 16'h0041);
    @(posedge clk);
    #10 prev = pixel_clock_out;
    @(posedge clk);
    #10 p1 = pixel_clock_out;
    for (int i = 0; i < 8; i++) begin
      pclk_at_high(~prev, "bin four pixel clock");
      prev = p1;
      p1 = pixel_clock_out;
    end
    @(posedge clk);
    ce <= 1'b0;
    #10 prev = pixel_clock_out;
    repeat (3) pclk_at_high(prev, "clock enable freeze");
    @(posedge clk);
    ce <= 1'b1;
    // Slave mode and stereo error
    do_reset();
    reg_wr(CTRL_ADDR, 16'h0000);
    repeat (2) @(posedge clk);
    check(ls_oe === 1'b0 && fs_oe === 1'b0, "slave sync input");
    pulse_sync(1'b1);
    pulse_sync(1'b0);
    repeat (100) @(posedge clk);
    pulse_sync(1'b0);
    repeat (10) @(posedge clk);
    check(error_out === 1'b1, "error flag set");
    reg_rd(ERR_ADDR, 16'h0001, "error reg set");
    reg_wr(ERR_ADDR, 16'h0001);
    repeat (2) @(posedge clk);
    check(error_out === 1'b0, "error flag clear");
    reg_rd(ERR_ADDR, 16'h0000, "error reg clear");
    finish_test();
  end
endmodule // image_sensor_pixel_readout_tb
`default_nettype wire
